// >>> design/vsl_supervision.sv
// voltage transformer supervision: pick-up, blocking, delay, events, log
//
// Function
// R1 - pick-up: one low, or two high
// R2 - blocking sampled at each program cycle start
// R3 - pick-up unblocked raises start, starts delay
// R4 - pick-up while blocked raises blocked only
// R5 - block during start drops start, resets timer
// R6 - blocking gives display and stamped event
// R7 - blocking must arrive 5 ms before expiry
// R8 - definite fixed delay from start to trip
// R9 - ON/OFF events, selectable per event
// R10 - events carry timestamp and process data
// R11 - six conditions, twelve events total
// R12 - keep latest twelve ON records
// R13 - record voltage status 0/1/2
// R14 - record angles, remaining time, setting group
// R15 - bus voltage state codes 0 to 4
// R16 - condition codes 0 to 4
// R17 - block mode codes 1 to 5
// R18 - expected operating time in 5 ms steps
// R19 - signed remaining time counting down
// R20 - thirteenth record overwrites the oldest
//
// The implementer's own choices: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
module vsl_supervision
  import vsl_pkg::*;
#(
  parameter int CYC_CLKS = CYCLE_CLKS,
  parameter int MS_CLKS  = STAMP_CLKS
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // avalon-mm slave
  input  wire logic [7:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  output logic [31:0]      readdata,
  output logic             waitrequest,
  // measurements, same clock domain
  input  wire vsl_meas_s   meas,
  // pins: block, line vt fail, bus fuse, line fuse
  input  wire logic [3:0]  pin_in,
  // outputs to blocking matrix, event buffer and display
  output logic             start_out,
  output logic             trip_out,
  output logic             blocked_out,
  output logic             display_evt,
  output logic             evt_valid,
  output vsl_evt_s         evt
);
  // ----------------------------------------------------------------
  // registers and state
  // ----------------------------------------------------------------
  logic [2:0]  mode;
  logic [2:0]  sg;
  logic [11:0] evt_en;
  logic [15:0] low_lvl, high_lvl;
  logic [18:0] delay, elapsed;
  logic [3:0]  log_idx;
  logic [31:0] cyc_cnt, ms_cnt, stamp;
  logic [3:0]  sync1, sync2;
  logic        blk_smp, trip_int;
  logic [NCOND-1:0] prev, pend_on, pend_off;
  logic [2:0][15:0] start_volt;

  // ----------------------------------------------------------------
  // program cycle and millisecond stamp
  // ----------------------------------------------------------------
  wire tick    = (cyc_cnt == 32'(CYC_CLKS - 1));
  wire ms_tick = (ms_cnt == 32'(MS_CLKS - 1));

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cyc_cnt <= 32'h0;
      ms_cnt  <= 32'h0;
      stamp   <= 32'h0;
      sync1   <= 4'h0;
      sync2   <= 4'h0;
    end else begin
      cyc_cnt <= tick ? 32'h0 : cyc_cnt + 32'h1;
      ms_cnt  <= ms_tick ? 32'h0 : ms_cnt + 32'h1;
      stamp   <= ms_tick ? stamp + 32'h1 : stamp;
      sync1   <= pin_in;
      sync2   <= sync1;
    end
  end

  // ----------------------------------------------------------------
  // voltage evaluation
  // ----------------------------------------------------------------
  logic [3:0] below, above;
  logic [3:0][1:0] vstat;
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_volt
      assign below[gi] = meas.volt[gi] < low_lvl;
      assign above[gi] = meas.volt[gi] > high_lvl;
      assign vstat[gi] = below[gi] ? VST_NONE :
                         (above[gi] ? VST_OK : VST_LOW); // R13
    end
  endgenerate

  wire two_high = (above[0] & above[1]) | (above[1] & above[2]) | (above[0] & above[2]);
  wire pickup   = (|below[2:0]) | two_high; // R1
  wire active   = (mode == MODE_ON) || (mode == MODE_TEST); // R17
  wire pk       = pickup & active;
  // block read straight at the cycle start, before this cycle's decision
  wire blk_now  = sync2[0]; // R2
  wire [2:0] bus_state = (&below[2:0]) ? BUS_DEAD :
                         pickup ? BUS_PROBLEM : 3'(meas.seq) + 3'h1; // R15
  wire [2:0] cond = blocked_out ? COND_BLOCKED :
                    sync2[1] ? COND_LINE_VT :
                    trip_int ? COND_BUS_VT :
                    start_out ? COND_START : COND_NORMAL; // R16
  wire [19:0] remain = start_out ? 20'(delay) - 20'(elapsed) : 20'h0; // R19
  wire [NCOND-1:0] cur = {sync2[3], sync2[2], sync2[1], blocked_out, trip_int, start_out};

  // ----------------------------------------------------------------
  // start, blocking and definite-time delay
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      start_out   <= 1'b0;
      blocked_out <= 1'b0;
      trip_int    <= 1'b0;
      trip_out    <= 1'b0;
      elapsed     <= 19'h0;
      blk_smp     <= 1'b0;
      start_volt  <= '0;
    end else if (tick) begin
      blk_smp <= blk_now; // R2
      if (pk && !blk_now) begin
        start_out   <= 1'b1; // R3
        blocked_out <= 1'b0;
        if (!start_out) begin
          start_volt <= meas.volt[2:0];
        end
        elapsed  <= start_out ? elapsed + 19'h1 : 19'h0;
        trip_int <= start_out && (elapsed + 19'h1 >= delay); // R8
        trip_out <= start_out && (elapsed + 19'h1 >= delay) && mode != MODE_TEST;
      end else begin
        // blocked and released paths reset the timer alike
        start_out   <= 1'b0; // R5
        blocked_out <= pk; // R4
        trip_int    <= 1'b0;
        trip_out    <= 1'b0;
        elapsed     <= 19'h0; // R5
      end
    end
  end

  // ----------------------------------------------------------------
  // event queue: edges of six conditions, drained one per clock
  // ----------------------------------------------------------------
  wire [NCOND-1:0] rise = tick ? (cur & ~prev) : '0;
  wire [NCOND-1:0] fall = tick ? (~cur & prev) : '0;
  wire             any_on = |pend_on;
  wire [2:0]       sel = first_set(any_on ? pend_on : pend_off);
  wire             emit = any_on | (|pend_off);
  wire [3:0]       code = {sel, ~any_on}; // R11
  wire [NCOND-1:0] clr  = emit ? (NCOND'(1) << sel) : '0;

  function automatic logic [2:0] first_set(input logic [NCOND-1:0] v);
    logic [2:0] r;
    r = 3'h0;
    for (int i = NCOND - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = 3'(i);
      end
    end
    return r;
  endfunction : first_set

  vsl_rec_s rec;
  assign rec = '{stamp: stamp, code: code, vstat: vstat, sys: bus_state,
                 angle: meas.angle, remain: remain, sg: sg}; // R14

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      prev        <= '0;
      pend_on     <= '0;
      pend_off    <= '0;
      evt_valid   <= 1'b0;
      evt         <= '0;
      display_evt <= 1'b0;
    end else begin
      prev        <= tick ? cur : prev;
      // fresh edge wins over the drain of the same bit
      pend_on     <= (pend_on & ~(any_on ? clr : '0)) | rise; // R9
      pend_off    <= (pend_off & ~(any_on ? '0 : clr)) | fall; // R9
      evt_valid   <= emit && evt_en[code]; // R9
      evt         <= '{stamp: stamp, code: code, fault: cond,
                       start_volt: start_volt}; // R10
      display_evt <= rise[2]; // R6
    end
  end

  wire log_wr = emit & any_on; // R12
  vsl_rec_s   log_rd;
  logic [3:0] log_cnt;
  vsl_oplog #(.DEPTH(LOG_DEPTH)) u_log (
    .clk     (clk),
    .rstn    (rstn),
    .wr      (log_wr),
    .wdata   (rec),
    .rd_idx  (log_idx),
    .rd_data (log_rd),
    .count   (log_cnt)
  );

  // ----------------------------------------------------------------
  // avalon-mm slave: one wait state on every access
  // ----------------------------------------------------------------
  logic [31:0] rmux;
  wire [31:0] status = {12'h0, log_cnt, 1'b0, blk_smp, trip_int, blocked_out,
                        1'b0, bus_state, 1'b0, mode, 1'b0, cond};
  wire [2:0][31:0] log_w = {{12'h0, log_rd.remain},
                            {log_rd.angle[3], log_rd.angle[2]},
                            {log_rd.angle[1], log_rd.angle[0]}};
  wire [7:0] lw = address - REG_LOG_W0;

  always_comb begin
    rmux = 32'h0;
    case (address)
      REG_CTRL:    rmux = {25'h0, sg, 1'b0, mode};
      REG_EVT_EN:  rmux = {20'h0, evt_en};
      REG_LOW:     rmux = {16'h0, low_lvl};
      REG_HIGH:    rmux = {16'h0, high_lvl};
      REG_DELAY:   rmux = {13'h0, delay};
      REG_STATUS:  rmux = status;
      REG_REMAIN:  rmux = {{12{remain[19]}}, remain}; // R19
      REG_EXPECT:  rmux = {13'h0, delay}; // R18
      REG_LOG_IDX: rmux = {28'h0, log_idx};
      default: begin
        if (address >= REG_LOG_W0 && lw < 8'(4 * LOG_WORDS) && lw[1:0] == 2'h0) begin
          case (lw[4:2])
            3'h0:    rmux = log_rd.stamp;
            3'h1:    rmux = {14'h0, log_rd.sg, log_rd.sys, log_rd.vstat, log_rd.code};
            default: rmux = log_w[lw[4:2] - 3'h2];
          endcase
        end
      end
    endcase
  end

  wire wr_take = write && !waitrequest;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      waitrequest <= 1'b1;
      readdata    <= 32'h0;
      mode        <= MODE_RST;
      sg          <= SG_RST;
      evt_en      <= EVT_EN_RST;
      low_lvl     <= LOW_RST;
      high_lvl    <= HIGH_RST;
      delay       <= DELAY_RST;
      log_idx     <= 4'h0;
    end else begin
      waitrequest <= !((read || write) && waitrequest);
      readdata    <= (read && waitrequest) ? rmux : readdata;
      if (wr_take) begin
        case (address)
          REG_CTRL: begin
            mode <= (writedata[2:0] >= MODE_ON && writedata[2:0] <= MODE_OFF) ?
                    writedata[2:0] : mode; // R17
            sg   <= writedata[CTRL_SG_LSB +: 3];
          end
          REG_EVT_EN:  evt_en   <= writedata[11:0];
          REG_LOW:     low_lvl  <= writedata[15:0];
          REG_HIGH:    high_lvl <= writedata[15:0];
          REG_DELAY:   delay    <= writedata[18:0];
          REG_LOG_IDX: log_idx  <= writedata[3:0];
          default:     ;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  AST_START_RISE: assert property (tick && pk && !blk_now |=> start_out) // R3
    else $error("start not raised on unblocked pick-up");
  AST_BLOCK_ONLY: assert property (tick && pk && blk_now |=> blocked_out && !start_out) // R4
    else $error("blocked pick-up did not give blocked only");
  AST_BLOCK_DROP: assert property (start_out && tick && blk_now |=> !start_out && elapsed == 19'h0) // R5
    else $error("start kept or timer kept under blocking");
  AST_TRIP_DT: assert property ($rose(trip_int) |-> $past(start_out) && elapsed >= delay) // R8
    else $error("trip before the set delay");
  AST_REMAIN: assert property (start_out && !tick && !wr_take |=> $stable(remain)) // R19
    else $error("remaining time moved between program cycles");
  AST_COND_BLK: assert property (blocked_out |-> cond == COND_BLOCKED) // R16
    else $error("condition code not blocked while blocked");
  AST_BUS_RANGE: assert property (bus_state <= BUS_PROBLEM &&
    (!pickup || bus_state == BUS_PROBLEM || (&below[2:0]))) // R15
    else $error("bus voltage state out of range");
  AST_EVT_MASK: assert property (evt_valid |-> evt_en[evt.code]) // R9
    else $error("event emitted against its selection");
  AST_DISPLAY: assert property (tick && blocked_out && !prev[2] |=> display_evt) // R6
    else $error("display event missing on blocking");
  AST_WAIT_ONE: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("bus access not answered after one wait state");

  COV_TRIP:  cover property ($rose(trip_int));
  COV_BLOCK: cover property (start_out && tick && blk_now && pk);
  COV_LOG:   cover property (log_wr && log_cnt == 4'(LOG_DEPTH));
endmodule : vsl_supervision
`default_nettype wire

// >>> design/vsl_pkg.sv
// package: register map, codes and record layouts of the supervision block
package vsl_pkg;
  // ----------------------------------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CTRL    = 8'h00;
  localparam logic [7:0] REG_EVT_EN  = 8'h04;
  localparam logic [7:0] REG_LOW     = 8'h08;
  localparam logic [7:0] REG_HIGH    = 8'h0c;
  localparam logic [7:0] REG_DELAY   = 8'h10;
  localparam logic [7:0] REG_STATUS  = 8'h14;
  localparam logic [7:0] REG_REMAIN  = 8'h18;
  localparam logic [7:0] REG_EXPECT  = 8'h1c;
  localparam logic [7:0] REG_LOG_IDX = 8'h20;
  localparam logic [7:0] REG_LOG_W0  = 8'h24;
  localparam int         LOG_WORDS   = 5;
  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int          CTRL_SG_LSB  = 4;
  localparam int          ST_MODE_LSB  = 4;
  localparam int          ST_BUS_LSB   = 8;
  localparam int          ST_FLAG_LSB  = 12;
  localparam int          ST_CNT_LSB   = 16;
  localparam logic [2:0]  MODE_RST     = 3'h1;
  localparam logic [2:0]  SG_RST       = 3'h1;
  localparam logic [11:0] EVT_EN_RST   = 12'hfff;
  localparam logic [15:0] LOW_RST      = 16'h0005;
  localparam logic [15:0] HIGH_RST     = 16'h0050;
  localparam logic [18:0] DELAY_RST    = 19'h00014;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_NS       = 10;
  localparam int CYCLE_MS     = 5;
  localparam int STAMP_MS     = 1;
  localparam int CYCLE_CLKS   = (CYCLE_MS * 1000000) / CLK_NS;
  localparam int STAMP_CLKS   = (STAMP_MS * 1000000) / CLK_NS;
  localparam int LOG_DEPTH    = 12;
  // ----------------------------------------------------------------
  // codes
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    MODE_ON = 3'h1, MODE_BLOCKED = 3'h2, MODE_TEST = 3'h3,
    MODE_TEST_BLK = 3'h4, MODE_OFF = 3'h5
  } vsl_mode_e;
  localparam logic [2:0] COND_NORMAL  = 3'h0;
  localparam logic [2:0] COND_START   = 3'h1;
  localparam logic [2:0] COND_LINE_VT = 3'h2;
  localparam logic [2:0] COND_BUS_VT  = 3'h3;
  localparam logic [2:0] COND_BLOCKED = 3'h4;
  localparam logic [2:0] BUS_DEAD     = 3'h0;
  localparam logic [2:0] BUS_PROBLEM  = 3'h4;
  localparam logic [1:0] VST_NONE     = 2'h0;
  localparam logic [1:0] VST_OK       = 2'h1;
  localparam logic [1:0] VST_LOW      = 2'h2;
  // condition index: start, trip, block, line vt, bus fuse, line fuse
  localparam int NCOND = 6;
  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [3:0][15:0] volt;
    logic [1:0]       seq;
    logic [3:0][15:0] angle;
  } vsl_meas_s;
  typedef struct packed {
    logic [31:0]       stamp;
    logic [3:0]        code;
    logic [3:0][1:0]   vstat;
    logic [2:0]        sys;
    logic [3:0][15:0]  angle;
    logic [19:0]       remain;
    logic [2:0]        sg;
  } vsl_rec_s;
  typedef struct packed {
    logic [31:0]      stamp;
    logic [3:0]       code;
    logic [2:0]       fault;
    logic [2:0][15:0] start_volt;
  } vsl_evt_s;
endpackage : vsl_pkg

// >>> design/vsl_oplog.sv
// twelve-deep ring of operation records, newest first on readback
`timescale 1ns/1ps
`default_nettype none
module vsl_oplog
  import vsl_pkg::*;
#(
  parameter int DEPTH = LOG_DEPTH
) (
  // clock and reset
  input  wire logic      clk,
  input  wire logic      rstn,
  // write side
  input  wire logic      wr,
  input  wire vsl_rec_s  wdata,
  // read side, idx 0 is the newest record
  input  wire logic [3:0] rd_idx,
  output vsl_rec_s        rd_data,
  output logic [3:0]      count
);
  vsl_rec_s   mem [DEPTH];
  logic [3:0] wp;
  logic [4:0] raw;
  logic [3:0] ra;

  // oldest slot is reused once full
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wp    <= 4'h0;
      count <= 4'h0;
    end else if (wr) begin
      wp    <= (wp == 4'(DEPTH - 1)) ? 4'h0 : wp + 4'h1; // R20
      count <= (count == 4'(DEPTH)) ? count : count + 4'h1; // R12
    end
  end

  always_ff @(posedge clk) begin
    if (wr) begin
      mem[wp] <= wdata; // R12
    end
  end

  assign raw = 5'(wp) + 5'(DEPTH) - 5'h1 - 5'(rd_idx);
  assign ra  = (raw >= 5'(DEPTH)) ? 4'(raw - 5'(DEPTH)) : raw[3:0];
  assign rd_data = (rd_idx < count) ? mem[ra] : '0;

  AST_LOG_FULL: assert property (@(posedge clk) disable iff (!rstn)
    wr && count == 4'(DEPTH) |=> count == 4'(DEPTH) && $changed(wp)) // R20
    else $error("log count left full state on overwrite");
endmodule : vsl_oplog
`default_nettype wire

// >>> verification/vsl_far_side.sv
// far-side model: blocking matrix pins and event buffer of the relay
`timescale 1ns/1ps
`default_nettype none
module vsl_far_side
  import vsl_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rstn,
  // blocking matrix requests from the bench
  input  wire logic [3:0] req,
  output logic [3:0]      pin_in,
  // event buffer and display
  input  wire logic       evt_valid,
  input  wire vsl_evt_s   evt,
  input  wire logic       display_evt
);
  int          cnt [12];
  logic [31:0] stamp_of [12];
  logic [15:0] blk_volt;
  logic [2:0]  blk_fault;
  int          n_disp;
  // matrix outputs are levels, held until the bench changes them
  assign pin_in = req;
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      n_disp <= 0;
      foreach (cnt[i]) cnt[i] <= 0;
    end else begin
      if (display_evt) n_disp <= n_disp + 1;
      if (evt_valid && evt.code < 4'hc) begin
        cnt[evt.code]      <= cnt[evt.code] + 1;
        stamp_of[evt.code] <= evt.stamp;
        if (evt.code == 4'h4) begin
          blk_volt  <= evt.start_volt[0];
          blk_fault <= evt.fault;
        end
      end
    end
  end
endmodule : vsl_far_side
`default_nettype wire

// >>> verification/tb_top.sv
// self-checking bench of the supervision block
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin errors++; \
  $display("FAIL t=%0t got=%h exp=%h", $time, g, e); end end
module tb_top
  import vsl_pkg::*;
;
  localparam int CYC = 20;
  logic        clk;
  logic        rstn;
  logic [7:0]  address;
  logic        read;
  logic        write;
  logic [31:0] writedata;
  logic [31:0] readdata;
  logic        waitrequest;
  vsl_meas_s   meas;
  logic [3:0]  pin_in;
  logic [3:0]  req;
  logic        start_out;
  logic        trip_out;
  logic        blocked_out;
  logic        display_evt;
  logic        evt_valid;
  vsl_evt_s    evt;
  int          errors;
  int          n_compared;
  logic [31:0] q;
  int          k;

  vsl_supervision #(.CYC_CLKS(CYC), .MS_CLKS(4)) vsl_supervision_i (
    .clk(clk), .rstn(rstn), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .meas(meas), .pin_in(pin_in), .start_out(start_out), .trip_out(trip_out),
    .blocked_out(blocked_out), .display_evt(display_evt),
    .evt_valid(evt_valid), .evt(evt));

  vsl_far_side vsl_far_side_i (
    .clk(clk), .rstn(rstn), .req(req), .pin_in(pin_in),
    .evt_valid(evt_valid), .evt(evt), .display_evt(display_evt));

  // ----------------------------------------------------------------
  // bus access and helpers
  // ----------------------------------------------------------------
  // raised one edge after the call, so a release is never overwritten in one step;
  // waitrequest and read data are taken at the accepting rising edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    address   <= a;
    read      <= ~wr;
    write     <= wr;
    writedata <= d;
    n = 0;
    do begin @(posedge clk); n++; end while (waitrequest !== 1'b0 && n < 50);
    if (n >= 50) errors++;
    q = readdata;
    read  <= 1'b0;
    write <= 1'b0;
  endtask : bus

  task automatic ticks(input int n);
    repeat (n * CYC) @(posedge clk);
  endtask : ticks

  // sel 0 waits for start, anything else for blocked
  task automatic wait_hi(input int sel);
    for (k = 0; k < 8 * CYC && (sel == 0 ? start_out : blocked_out) !== 1'b1; k++)
      @(posedge clk);
  endtask : wait_hi

  task automatic set_v0(input logic [15:0] v);
    @(posedge clk);
    meas.volt[0] <= v;
  endtask : set_v0

  task automatic test_done;
    if (errors == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : test_done

  // ----------------------------------------------------------------
  // clock, reset, watchdog
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    repeat (40000) @(posedge clk);
    errors++;
    test_done();
  end

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    errors = 0; n_compared = 0;
    rstn = 1'b0; address = 8'h00; read = 1'b0; write = 1'b0;
    writedata = 32'h0; req = 4'h0;
    meas = '0;
    meas.volt = {16'h0060, 16'h0040, 16'h0040, 16'h0040};
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    // reset values and unmapped place
    bus(0, REG_CTRL, 0);   `CHK(q, 32'h0000_0011)
    bus(0, REG_EVT_EN, 0); `CHK(q, 32'h0000_0fff)
    bus(0, REG_DELAY, 0);  `CHK(q, 32'h0000_0014)
    bus(0, REG_EXPECT, 0); `CHK(q, 32'h0000_0014)
    bus(0, 8'hfc, 0);      `CHK(q, 32'h0000_0000)
    // every mode, then an illegal one that must not stick
    for (int m = 1; m <= 5; m++) begin
      bus(1, REG_CTRL, 32'h10 | m);
      bus(0, REG_STATUS, 0); `CHK(q[6:4], 3'(m))
    end
    bus(1, REG_CTRL, 32'h17);
    bus(0, REG_STATUS, 0); `CHK(q[6:4], MODE_OFF)
    bus(1, REG_CTRL, 32'h11);
    // live bus, each sequence state
    for (int s = 0; s < 3; s++) begin
      @(posedge clk);
      meas.seq <= 2'(s);
      ticks(2);
      bus(0, REG_STATUS, 0);
      `CHK(q[10:8], 3'(s + 1))
      `CHK(q[2:0], COND_NORMAL)
    end
    meas.seq <= 2'h0;
    // short delay, start OFF events masked
    bus(1, REG_DELAY, 32'h3);
    bus(1, REG_EVT_EN, 32'hffd);
    bus(0, REG_EXPECT, 0); `CHK(q, 32'h3)
    // one low voltage picks up, unblocked: start, then trip after delay
    set_v0(16'h0002);
    wait_hi(0); `CHK(start_out, 1'b1)
    bus(0, REG_REMAIN, 0); `CHK(q, 32'h3)
    bus(0, REG_STATUS, 0);
    `CHK(q[2:0], COND_START)
    `CHK(q[10:8], BUS_PROBLEM)
    for (k = 6; k < 8 * CYC && trip_out !== 1'b1; k++) @(posedge clk);
    `CHK(k, 3 * CYC)
    // trip edge is seen at the next tick and drained one clock later
    ticks(2);
    `CHK(vsl_far_side_i.cnt[0], 1)
    `CHK(vsl_far_side_i.cnt[2], 1)
    `CHK(vsl_far_side_i.stamp_of[2] - vsl_far_side_i.stamp_of[0], 32'd15)
    bus(1, REG_LOG_IDX, 0);
    bus(0, 8'h28, 0); `CHK(q[17:0], 18'h0c682)
    bus(0, REG_STATUS, 0); `CHK(q[19:16], 4'h2)
    // pick-up gone: OFF events only where enabled
    set_v0(16'h0040);
    ticks(3);
    `CHK(trip_out, 1'b0)
    `CHK(vsl_far_side_i.cnt[1], 0)
    `CHK(vsl_far_side_i.cnt[3], 1)
    // block arrives while started, well before expiry
    set_v0(16'h0002);
    wait_hi(0);
    @(posedge clk);
    req <= 4'h1;
    wait_hi(1); `CHK(blocked_out, 1'b1)
    `CHK(start_out, 1'b0)
    bus(0, REG_REMAIN, 0); `CHK(q, 32'h0)
    ticks(4);
    `CHK(trip_out, 1'b0)
    `CHK(vsl_far_side_i.n_disp, 1)
    `CHK(vsl_far_side_i.cnt[4], 1)
    `CHK(vsl_far_side_i.blk_volt, 16'h0002)
    `CHK(vsl_far_side_i.blk_fault, COND_BLOCKED)
    bus(0, REG_STATUS, 0); `CHK(q[2:0], COND_BLOCKED)
    // pick-up again with block held: never starts
    set_v0(16'h0040);
    ticks(2);
    set_v0(16'h0003);
    ticks(4);
    `CHK(start_out, 1'b0)
    `CHK(blocked_out, 1'b1)
    // fill the log past its depth
    set_v0(16'h0040);
    @(posedge clk);
    req <= 4'h0;
    ticks(2);
    for (int n = 0; n < 13; n++) begin
      set_v0(16'h0002);
      ticks(2);
      set_v0(16'h0040);
      ticks(2);
    end
    bus(0, REG_STATUS, 0); `CHK(q[19:16], 4'hc)
    bus(0, 8'h28, 0); `CHK(q[3:0], 4'h0)
    bus(1, REG_LOG_IDX, 32'hc);
    bus(0, 8'h28, 0); `CHK(q, 32'h0)
    // test mode: timer runs to operation but the operate output stays low
    bus(1, REG_CTRL, 32'h13);
    set_v0(16'h0002);
    ticks(5);
    bus(0, REG_STATUS, 0); `CHK(q[13], 1'b1)
    `CHK(trip_out, 1'b0)
    bus(1, REG_CTRL, 32'h15);
    ticks(2);
    `CHK(start_out, 1'b0)
    `CHK(blocked_out, 1'b0)
    // line vt failure pin: condition code and its ON event
    req <= 4'h2;
    ticks(2);
    bus(0, REG_STATUS, 0); `CHK(q[2:0], COND_LINE_VT)
    `CHK(vsl_far_side_i.cnt[6], 1)
    test_done();
  end
endmodule : tb_top
`default_nettype wire
